// >>> crm_mapper.sv
// How it works
// (RULE_01) 64 entries; zero pointer suppresses message
// (RULE_02) Direction flag: 1 command in, 0 report
// (RULE_03) Entry k uses base identifier plus k
// (RULE_04) Four independent bulk report blocks
// (RULE_05) First bulk block starts at base plus 64
// (RULE_06) Next block starts after previous block's count
// (RULE_07) Zero start pointer silences whole bulk block
// (RULE_08) Enable pointer register gates each element
// (RULE_09) Both pointers advance by stride per element
// (RULE_10) Exactly count elements read per block
// (RULE_11) Bulk and single messages share one format
// (RULE_12) Connection state codes zero to four
// (RULE_13) Host aligns value and enable pointers
// (RULE_14) Host sets stride to instance register count
// (RULE_15) Host keeps all identifiers within 11 bits
// (RULE_16) Microsecond pause after every report message
// (RULE_17) Matching command frame writes pointed register
// (RULE_18) Reports only while reporting is on; a report already under way when it is cleared is still sent
// (RULE_19) Skipped entries keep their identifier slots
// (RULE_20) Zero enable skips element, identifiers unshifted
`timescale 1ns/1ns
`default_nettype none
`include "crm_defines.svh"

module crm_mapper (
  input  wire logic                   clk_sys,
  input  wire logic                   arst_n,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output var  logic [31:0]            prdata,
  output var  logic                   pready,
  output var  logic                   pslverr,
  output var  logic                   rd_req,
  output var  logic [15:0]            rd_addr,
  input  wire logic [31:0]            rd_data,
  input  wire logic                   rd_ack,
  output var  logic                   tx_valid,
  output var  crm_pkg::crm_frame_type tx,
  input  wire logic                   tx_ready,
  input  wire logic                   rx_valid,
  input  wire crm_pkg::crm_frame_type rx,
  output var  logic                   rx_ready,
  output var  logic                   wr_valid,
  output var  crm_pkg::crm_wr_type    wr,
  input  wire logic                   wr_ready
);

  // Whole block state and its next value
  crm_pkg::crm_top_state_type s;
  crm_pkg::crm_top_state_type next_s;
  logic                       pause_done;
  logic                       period_done;

  // Identifier arithmetic, wrapping inside the 11-bit space
  function automatic logic [10:0] id_add(input logic [10:0] base, input logic [10:0] off);
    id_add = base + off;
  endfunction : id_add

  // Advance a walk pointer by one component instance
  function automatic logic [15:0] ptr_step(input logic [15:0] p, input logic [15:0] stride);
    ptr_step = p + stride;
  endfunction : ptr_step

  // Entry table page: one word per entry
  function automatic logic in_entry_page(input logic [11:0] a);
    in_entry_page = (a[11:8] == `CRM_ENTRY_PAGE);
  endfunction : in_entry_page

  // Bulk table page: four words per block
  function automatic logic in_bulk_page(input logic [11:0] a);
    in_bulk_page = (a[11:6] == `CRM_BULK_PAGE);
  endfunction : in_bulk_page

  // Field of a bulk block selected by the word inside the block
  function automatic logic [1:0] bulk_word(input logic [11:0] a);
    bulk_word = a[3:2];
  endfunction : bulk_word

  // Register map decode shared by read and write
  function automatic logic mapped(input logic [11:0] a);
    if (a == `CRM_CTRL_OFS || a == `CRM_BASE_ID_OFS || a == `CRM_PAUSE_OFS) begin
      mapped = 1'b1;
    end else if (a == `CRM_PERIOD_OFS || a == `CRM_STATUS_OFS) begin
      mapped = 1'b1;
    end else if (in_entry_page(a) || in_bulk_page(a)) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  endfunction : mapped

  // Pause between report messages
  crm_us_timer pause_tmr (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .start   (s.pause_go),
    .load_us (s.pause),
    .done    (pause_done)
  );

  // Period between report rounds
  crm_us_timer period_tmr (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .start   (s.period_go),
    .load_us (s.period),
    .done    (period_done)
  );

  // Incoming command frames
  crm_cmd_sink cmd_sink (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .base_id  (s.base),
    .entry    (s.entry),
    .rx_valid (rx_valid),
    .rx       (rx),
    .rx_ready (rx_ready),
    .wr_valid (wr_valid),
    .wr       (wr),
    .wr_ready (wr_ready)
  );

  // Bus slave, register file and report walker
  always_comb begin
    // Read data, entry slot, bulk block and the walker's next block
    logic [31:0] rdata;
    logic [5:0]  ei;
    logic [1:0]  bi;
    logic [1:0]  nb;
    rdata  = 32'h0000_0000;
    ei     = paddr[7:2];
    bi     = paddr[5:4];
    nb     = 2'(s.blk + 3'h1);
    next_s = s;
    // Timer launch strobes last one cycle
    next_s.pause_go  = 1'b0;
    next_s.period_go = 1'b0;

    // Read mux, sampled in the setup cycle
    if (paddr == `CRM_CTRL_OFS) begin
      rdata[`CRM_CTRL_ON_BIT] = s.on;
    end else if (paddr == `CRM_BASE_ID_OFS) begin
      rdata[10:0] = s.base;
    end else if (paddr == `CRM_PAUSE_OFS) begin
      rdata = s.pause;
    end else if (paddr == `CRM_PERIOD_OFS) begin
      rdata = s.period;
    end else if (paddr == `CRM_STATUS_OFS) begin
      rdata[`CRM_STAT_BUSY_BIT] = (s.st != crm_pkg::ST_IDLE);
      rdata[26:16]              = s.cur_id;
      rdata[15:0]               = s.sent;
    end else if (in_entry_page(paddr)) begin
      rdata[`CRM_ENTRY_DIR_BIT] = s.entry[ei].dir;
      rdata[15:0]               = s.entry[ei].ptr;
    end else if (in_bulk_page(paddr)) begin
      // Value start, enable start, stride, count
      if (bulk_word(paddr) == 2'h0) begin
        rdata[15:0] = s.bulk[bi].vstart;
      end else if (bulk_word(paddr) == 2'h1) begin
        rdata[15:0] = s.bulk[bi].estart;
      end else if (bulk_word(paddr) == 2'h2) begin
        rdata[15:0] = s.bulk[bi].stride;
      end else begin
        rdata[15:0] = s.bulk[bi].count;
      end
    end

    // One wait-free access phase: answer ready in first access cycle
    if (psel && !penable) begin
      next_s.pready  = 1'b1;
      next_s.pslverr = !mapped(paddr);
      next_s.prdata  = pwrite ? 32'h0000_0000 : rdata;
    end else if (psel && penable && s.pready) begin
      next_s.pready  = 1'b0;
      next_s.pslverr = 1'b0;
      // Writes land at the edge that ends the access phase
      if (pwrite) begin
        if (paddr == `CRM_CTRL_OFS) begin
          next_s.on = pwdata[`CRM_CTRL_ON_BIT];
        end else if (paddr == `CRM_BASE_ID_OFS) begin
          next_s.base = pwdata[10:0];
        end else if (paddr == `CRM_PAUSE_OFS) begin
          next_s.pause = pwdata;
        end else if (paddr == `CRM_PERIOD_OFS) begin
          next_s.period = pwdata;
        end else if (in_entry_page(paddr)) begin
          next_s.entry[ei].dir = pwdata[`CRM_ENTRY_DIR_BIT]; // RULE_02
          next_s.entry[ei].ptr = pwdata[15:0]; // RULE_01
        end else if (in_bulk_page(paddr)) begin
          if (bulk_word(paddr) == 2'h0) begin
            next_s.bulk[bi].vstart = pwdata[15:0]; // RULE_04
          end else if (bulk_word(paddr) == 2'h1) begin
            next_s.bulk[bi].estart = pwdata[15:0];
          end else if (bulk_word(paddr) == 2'h2) begin
            next_s.bulk[bi].stride = pwdata[15:0];
          end else begin
            next_s.bulk[bi].count = pwdata[15:0];
          end
        end
      end
    end else begin
      // No transfer: no answer
      next_s.pready  = 1'b0;
      next_s.pslverr = 1'b0;
    end

    // Report walker
    case (s.st)
      // Start a round when enabled and the period has run out
      crm_pkg::ST_IDLE: begin
        if (s.on && !s.period_go && period_done) begin // RULE_18
          next_s.period_go = 1'b1;
          next_s.idx       = 7'h00;
          next_s.in_bulk   = 1'b0;
          next_s.st        = crm_pkg::ST_ENTRY;
        end
      end
      // Walk the individual entries in order
      crm_pkg::ST_ENTRY: begin
        if (!s.on) begin
          next_s.st = crm_pkg::ST_IDLE; // RULE_18
        end else if (s.idx == `CRM_ENTRY_END) begin
          next_s.blk     = 3'h0;
          next_s.elem    = 16'h0000;
          next_s.vptr    = s.bulk[0].vstart;
          next_s.eptr    = s.bulk[0].estart;
          next_s.cur_id  = id_add(s.base, `CRM_BULK_ID_OFS); // RULE_05
          next_s.in_bulk = 1'b1;
          next_s.st      = crm_pkg::ST_BULK;
        end else if (s.entry[s.idx[5:0]].ptr != `CRM_PTR_NONE && !s.entry[s.idx[5:0]].dir) begin // RULE_01 RULE_02
          next_s.cur_id  = id_add(s.base, {4'h0, s.idx}); // RULE_03
          next_s.rd_req  = 1'b1;
          next_s.rd_addr = s.entry[s.idx[5:0]].ptr;
          next_s.st      = crm_pkg::ST_VAL_RD;
        end else begin
          next_s.idx = s.idx + 7'h01; // RULE_19
        end
      end
      // Walk the bulk blocks, one element per step
      crm_pkg::ST_BULK: begin
        if (!s.on || s.blk == `CRM_BULK_END) begin
          next_s.st = crm_pkg::ST_IDLE; // RULE_18
        end else if (s.bulk[s.blk[1:0]].vstart == `CRM_PTR_NONE
                     || s.elem == s.bulk[s.blk[1:0]].count) begin // RULE_07 RULE_10
          // Skip what is left of the block; identifiers still advance
          next_s.cur_id = s.cur_id + 11'(s.bulk[s.blk[1:0]].count - s.elem); // RULE_06
          next_s.blk    = s.blk + 3'h1;
          next_s.elem   = 16'h0000;
          next_s.vptr   = s.bulk[nb].vstart;
          next_s.eptr   = s.bulk[nb].estart;
        end else begin
          next_s.rd_req  = 1'b1;
          next_s.rd_addr = s.eptr; // RULE_08
          next_s.st      = crm_pkg::ST_EN_RD;
        end
      end
      // Enable answer: zero skips the element but uses up its identifier
      crm_pkg::ST_EN_RD: begin
        if (rd_ack) begin
          next_s.rd_req = 1'b0;
          if (rd_data != 32'h0000_0000) begin
            next_s.st = crm_pkg::ST_VAL_REQ; // RULE_20
          end else begin
            next_s.elem   = s.elem + 16'h0001;
            next_s.vptr   = ptr_step(s.vptr, s.bulk[s.blk[1:0]].stride); // RULE_09
            next_s.eptr   = ptr_step(s.eptr, s.bulk[s.blk[1:0]].stride); // RULE_09
            next_s.cur_id = s.cur_id + 11'h001; // RULE_20
            next_s.st     = crm_pkg::ST_BULK;
          end
        end
      end
      // Value read after a one-cycle gap in the request
      crm_pkg::ST_VAL_REQ: begin
        next_s.rd_req  = 1'b1;
        next_s.rd_addr = s.vptr;
        next_s.st      = crm_pkg::ST_VAL_RD;
      end
      // Value answer becomes the frame payload
      crm_pkg::ST_VAL_RD: begin
        if (rd_ack) begin
          next_s.rd_req   = 1'b0;
          next_s.tx       = '{id: s.cur_id, data: rd_data}; // RULE_11 RULE_12
          next_s.tx_valid = 1'b1;
          next_s.st       = crm_pkg::ST_SEND;
        end
      end
      // Frame taken: launch the pause and move to the next slot
      crm_pkg::ST_SEND: begin
        if (tx_ready) begin
          next_s.tx_valid = 1'b0;
          next_s.pause_go = 1'b1; // RULE_16
          next_s.sent     = s.sent + 16'h0001;
          next_s.st       = crm_pkg::ST_PAUSE;
          if (s.in_bulk) begin
            next_s.elem   = s.elem + 16'h0001; // RULE_10
            next_s.vptr   = ptr_step(s.vptr, s.bulk[s.blk[1:0]].stride); // RULE_09
            next_s.eptr   = ptr_step(s.eptr, s.bulk[s.blk[1:0]].stride); // RULE_09
            next_s.cur_id = s.cur_id + 11'h001;
          end else begin
            next_s.idx = s.idx + 7'h01;
          end
        end
      end
      crm_pkg::ST_PAUSE: begin
        // Timer output is stale in the cycle the pause is launched
        if (!s.pause_go && pause_done) begin // RULE_16
          next_s.st = s.in_bulk ? crm_pkg::ST_BULK : crm_pkg::ST_ENTRY;
        end
      end
      default: begin
        next_s.st = crm_pkg::ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s        <= '0;
      s.st     <= crm_pkg::ST_IDLE;
      s.base   <= `CRM_BASE_ID_RST;
      s.pause  <= `CRM_PAUSE_RST;
      s.period <= `CRM_PERIOD_RST;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from state flops
  assign prdata   = s.prdata;
  assign pready   = s.pready;
  assign pslverr  = s.pslverr;
  assign rd_req   = s.rd_req;
  assign rd_addr  = s.rd_addr;
  assign tx_valid = s.tx_valid;
  assign tx       = s.tx;

endmodule : crm_mapper

`default_nettype wire

// >>> crm_defines.svh
`ifndef CRM_DEFINES_SVH
`define CRM_DEFINES_SVH

// Register byte offsets on the configuration bus
`define CRM_CTRL_OFS      12'h000
`define CRM_BASE_ID_OFS   12'h004
`define CRM_PAUSE_OFS     12'h008
`define CRM_PERIOD_OFS    12'h00C
`define CRM_STATUS_OFS    12'h010
`define CRM_ENTRY_PAGE    4'h1
`define CRM_BULK_PAGE     6'h08

// Field positions
`define CRM_CTRL_ON_BIT   0
`define CRM_ENTRY_DIR_BIT 31
`define CRM_STAT_BUSY_BIT 31

// Table sizes and identifier layout
`define CRM_ENTRY_LAST    7'h3F
`define CRM_ENTRY_END     7'h40
`define CRM_BULK_END      3'h4
`define CRM_BULK_ID_OFS   11'h040
`define CRM_PTR_NONE      16'h0000

// Reset values
`define CRM_BASE_ID_RST   11'h100
`define CRM_PAUSE_RST     32'h0000_03E8
`define CRM_PERIOD_RST    32'h0007_A120

// Timing: one microsecond in clock cycles
`define CRM_CLK_NS        20
`define CRM_US_NS         1000
`define CRM_CYC_PER_US    (`CRM_US_NS / `CRM_CLK_NS)

// Stack connection state codes carried in report payloads
`define CRM_CONN_DISCONNECTED  32'h0000_0000
`define CRM_CONN_PRECHARGE     32'h0000_0001
`define CRM_CONN_CONNECTING    32'h0000_0002
`define CRM_CONN_CONNECTED     32'h0000_0003
`define CRM_CONN_DISCONNECTING 32'h0000_0004

`endif

// >>> crm_pkg.sv
package crm_pkg;

  typedef struct packed {
    logic        dir;
    logic [15:0] ptr;
  } crm_entry_type;

  typedef struct packed {
    logic [15:0] vstart;
    logic [15:0] estart;
    logic [15:0] stride;
    logic [15:0] count;
  } crm_bulk_type;

  typedef struct packed {
    logic [10:0] id;
    logic [31:0] data;
  } crm_frame_type;

  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] data;
  } crm_wr_type;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ENTRY, ST_BULK, ST_EN_RD, ST_VAL_REQ, ST_VAL_RD, ST_SEND, ST_PAUSE
  } crm_step_type;

  typedef struct packed {
    logic [31:0] us_left;
    logic [5:0]  cyc;
    logic        done;
  } crm_timer_state_type;

  typedef struct packed {
    logic          rx_ready;
    logic          wr_valid;
    crm_wr_type    wr;
  } crm_sink_state_type;

  typedef struct packed {
    crm_step_type        st;
    logic [6:0]          idx;
    logic [2:0]          blk;
    logic [15:0]         elem;
    logic [15:0]         vptr;
    logic [15:0]         eptr;
    logic [10:0]         cur_id;
    logic                in_bulk;
    logic [15:0]         sent;
    logic                on;
    logic [10:0]         base;
    logic [31:0]         pause;
    logic [31:0]         period;
    crm_entry_type [63:0] entry;
    crm_bulk_type [3:0]  bulk;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    logic                rd_req;
    logic [15:0]         rd_addr;
    logic                tx_valid;
    crm_frame_type       tx;
    logic                pause_go;
    logic                period_go;
  } crm_top_state_type;

endpackage : crm_pkg

// >>> crm_us_timer.sv
`timescale 1ns/1ns
`default_nettype none
`include "crm_defines.svh"

module crm_us_timer (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic        start,
  input  wire logic [31:0] load_us,
  output var  logic        done
);

  localparam logic [5:0] CYC_LAST = 6'(`CRM_CYC_PER_US - 1);

  crm_pkg::crm_timer_state_type s;
  crm_pkg::crm_timer_state_type next_s;

  // Microsecond prescaler and countdown; done is high while idle
  always_comb begin
    next_s = s;
    if (start) begin
      next_s.us_left = load_us;
      next_s.cyc     = CYC_LAST;
    end else if (s.us_left != 32'h0000_0000) begin
      if (s.cyc == 6'h00) begin
        next_s.us_left = s.us_left - 32'h0000_0001;
        next_s.cyc     = CYC_LAST;
      end else begin
        next_s.cyc = s.cyc - 6'h01;
      end
    end
    next_s.done = (next_s.us_left == 32'h0000_0000);
  end

  // State register
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s <= '{us_left: 32'h0000_0000, cyc: 6'h00, done: 1'b1};
    end else begin
      s <= next_s;
    end
  end

  assign done = s.done;

endmodule : crm_us_timer

`default_nettype wire

// >>> crm_cmd_sink.sv
`timescale 1ns/1ns
`default_nettype none
`include "crm_defines.svh"

module crm_cmd_sink (
  input  wire logic                      clk_sys,
  input  wire logic                      arst_n,
  input  wire logic [10:0]               base_id,
  input  wire crm_pkg::crm_entry_type [63:0] entry,
  input  wire logic                      rx_valid,
  input  wire crm_pkg::crm_frame_type    rx,
  output var  logic                      rx_ready,
  output var  logic                      wr_valid,
  output var  crm_pkg::crm_wr_type       wr,
  input  wire logic                      wr_ready
);

  crm_pkg::crm_sink_state_type s;
  crm_pkg::crm_sink_state_type next_s;

  // Match received identifier against command entries and issue a write
  always_comb begin
    logic [10:0] diff;
    diff   = rx.id - base_id;
    next_s = s;
    if (s.wr_valid && wr_ready) begin
      next_s.wr_valid = 1'b0;
      next_s.rx_ready = 1'b1;
    end
    if (rx_valid && s.rx_ready && diff < {4'h0, `CRM_ENTRY_END}) begin
      if (entry[diff[5:0]].dir && entry[diff[5:0]].ptr != `CRM_PTR_NONE) begin // RULE_17
        next_s.wr_valid = 1'b1;
        next_s.rx_ready = 1'b0;
        next_s.wr       = '{addr: entry[diff[5:0]].ptr, data: rx.data}; // RULE_17
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s <= '{rx_ready: 1'b1, wr_valid: 1'b0, wr: '0};
    end else begin
      s <= next_s;
    end
  end

  assign rx_ready = s.rx_ready;
  assign wr_valid = s.wr_valid;
  assign wr       = s.wr;

endmodule : crm_cmd_sink

`default_nettype wire

// >>> crm_mapper_sva.sv
`timescale 1ns/1ns
`default_nettype none

module crm_mapper_sva (
  input wire logic                   clk_sys,
  input wire logic                   arst_n,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic                   rd_req,
  input wire logic [15:0]            rd_addr,
  input wire logic                   rd_ack,
  input wire logic                   tx_valid,
  input wire crm_pkg::crm_frame_type tx,
  input wire logic                   tx_ready,
  input wire logic                   rx_ready,
  input wire logic                   wr_valid,
  input wire crm_pkg::crm_wr_type    wr,
  input wire logic                   wr_ready
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  // Bus answers in the first access cycle, for one cycle only
  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  apb_single_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  apb_error_a: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr outside an answer");
  // Register reads hold until answered
  rd_hold_a: assert property (rd_req && !rd_ack |=> rd_req && $stable(rd_addr))
    else $error("read request not held");
  rd_drop_a: assert property (rd_req && rd_ack |=> !rd_req)
    else $error("read request not released");
  // Frames hold until taken, then a gap follows
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx))
    else $error("frame changed before taken");
  tx_gap_a: assert property (tx_valid && tx_ready |=> !tx_valid [*2])
    else $error("no gap after frame");
  // Command writes hold, block the receiver, then release it
  wr_hold_a: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr))
    else $error("command write not held");
  wr_done_a: assert property (wr_valid && wr_ready |=> !wr_valid && rx_ready)
    else $error("receiver not reopened");
  wr_block_a: assert property (wr_valid |-> !rx_ready)
    else $error("receiver open during write");
endmodule : crm_mapper_sva

bind crm_mapper crm_mapper_sva u_sva (
  .clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .rd_req(rd_req), .rd_addr(rd_addr), .rd_ack(rd_ack), .tx_valid(tx_valid),
  .tx(tx), .tx_ready(tx_ready), .rx_ready(rx_ready), .wr_valid(wr_valid), .wr(wr), .wr_ready(wr_ready)
);

`default_nettype wire

// >>> crm_far_model.sv
`timescale 1ns/1ns
`default_nettype none

module crm_far_model (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic        rd_req,
  input  wire logic [15:0] rd_addr,
  output var  logic [31:0] rd_data,
  output var  logic        rd_ack,
  output var  logic        tx_ready,
  output var  logic        wr_ready
);
  logic [1:0] wait_cnt;

  // Enable area answers 1 when address bit 1 is clear; values mirror address
  function automatic logic [31:0] value_of(input logic [15:0] a);
    if (a[15:12] == 4'hE) return {31'h0, ~a[1]};
    return {a, ~a};
  endfunction : value_of

  // Random wait before each answer; idle data toggles every cycle
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rd_ack   <= 1'b0;
      rd_data  <= 32'h0;
      wait_cnt <= 2'h0;
      tx_ready <= 1'b0;
      wr_ready <= 1'b0;
    end else begin
      tx_ready <= 1'($urandom);
      wr_ready <= 1'($urandom);
      rd_ack   <= 1'b0;
      rd_data  <= ~rd_data;
      if (rd_req && !rd_ack) begin
        if (wait_cnt == 2'h0) begin
          rd_ack   <= 1'b1;
          rd_data  <= value_of(rd_addr);
          wait_cnt <= 2'($urandom);
        end else begin
          wait_cnt <= wait_cnt - 2'h1;
        end
      end
    end
  end
endmodule : crm_far_model

`default_nettype wire

// >>> crm_mapper_bench.sv
`timescale 1ns/1ns
`default_nettype none

module crm_mapper_bench;
  logic                   clk_sys, arst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0]            paddr;
  logic [31:0]            pwdata, prdata, rd_data, r, rxd;
  logic                   rd_req, rd_ack, tx_valid, tx_ready, rx_valid, rx_ready;
  logic                   wr_valid, wr_ready, e;
  logic [15:0]            rd_addr;
  crm_pkg::crm_frame_type tx, rx;
  crm_pkg::crm_wr_type    wr;
  logic [47:0]            tq[$], wq[$], f;
  int                     num_errors, total_checks, cyc, tx_cnt, n;
  logic [11:0] rst_a [5]  = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h014};
  logic [31:0] rst_v [5]  = '{32'h0, 32'h100, 32'h3E8, 32'h0007_A120, 32'h0};
  logic [11:0] cfg_a [17] = '{12'h004, 12'h008, 12'h00C, 12'h100, 12'h104, 12'h108, 12'h10C, 12'h1FC,
    12'h200, 12'h204, 12'h208, 12'h20C, 12'h21C, 12'h220, 12'h224, 12'h228, 12'h22C};
  logic [31:0] cfg_v [17] = '{32'h200, 32'h0, 32'h1, 32'h10, 32'h8000_0000, 32'h8000_0020, 32'h30,
    32'h40, 32'h100, 32'hE000, 32'h2, 32'h4, 32'h3, 32'h200, 32'hE001, 32'h1, 32'h2};
  logic [10:0] exp_k [6]  = '{11'h0, 11'h3, 11'h3F, 11'h40, 11'h42, 11'h47};
  logic [15:0] exp_p [6]  = '{16'h10, 16'h30, 16'h40, 16'h100, 16'h104, 16'h200};
  logic [10:0] bad_id [3] = '{11'h201, 11'h203, 11'h246};

  crm_mapper DUT (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data), .rd_ack(rd_ack),
    .tx_valid(tx_valid), .tx(tx), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx(rx),
    .rx_ready(rx_ready), .wr_valid(wr_valid), .wr(wr), .wr_ready(wr_ready));
  crm_far_model u_far (.clk_sys(clk_sys), .arst_n(arst_n), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_data(rd_data), .rd_ack(rd_ack), .tx_ready(tx_ready), .wr_ready(wr_ready));

  // Clock at 50 MHz
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task chk(input string nm, input logic [47:0] exp, input logic [47:0] seen);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task final_report();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  // One bus transfer, held until pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (!pready);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Offer a received frame until taken
  task send_rx(input logic [10:0] id, input logic [31:0] d);
    @(posedge clk_sys);
    rx_valid <= 1'b1;
    rx       <= {id, d};
    do @(posedge clk_sys); while (!rx_ready);
    rx_valid <= 1'b0;
    rx       <= ~{id, d};
  endtask : send_rx

  // Watch frames and writes, compare with the oldest note; cut a hang short
  always @(posedge clk_sys) begin
    cyc++;
    if (tx_valid && tx_ready) tx_cnt++;
    if (tx_valid && tx_ready && tq.size() > 0) begin
      f = tq.pop_front();
      chk("frame id", 48'(f[42:32]), 48'(tx.id));
      chk("frame data", 48'(f[31:0]), 48'(tx.data));
    end
    if (wr_valid && wr_ready) chk("write", wq.size() > 0 ? wq.pop_front() : 'x, wr);
    if (cyc == 40000) begin
      num_errors++;
      final_report();
    end
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, rx_valid, rx, arst_n} = '0;
    void'($urandom(32'h5A2BAF5F));
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    // Reset values and an unmapped address
    foreach (rst_a[i]) begin
      apb(1'b0, rst_a[i], 32'h0);
      chk("reset", 48'(rst_v[i]), 48'(r));
      chk("slverr", 48'(i == 4), 48'(e));
    end
    // Report map: skipped and command entries, silent block, gated elements
    foreach (cfg_a[i]) apb(1'b1, cfg_a[i], cfg_v[i]);
    apb(1'b0, 12'h22C, 32'h0);
    chk("count", 48'h2, 48'(r));
    repeat (2) foreach (exp_k[i]) tq.push_back({5'h0, 11'h200 + exp_k[i], exp_p[i], ~exp_p[i]});
    apb(1'b1, 12'h000, 32'h1);
    while (tq.size() > 0) @(posedge clk_sys);
    // Command frames: one match, the rest dropped
    rxd = $urandom;
    wq.push_back({16'h0020, rxd});
    send_rx(11'h202, rxd);
    foreach (bad_id[i]) send_rx(bad_id[i], $urandom);
    repeat (20) @(posedge clk_sys);
    chk("pending", 48'(wq.size()), 48'h0);
    // Pause of 2 us between frames
    apb(1'b1, 12'h008, 32'h2);
    repeat (2) do @(posedge clk_sys); while (!(tx_valid && tx_ready));
    n = 0;
    while (!rd_req) begin
      @(posedge clk_sys);
      n++;
    end
    chk("gap", 48'h1, 48'(n >= 100));
    // Reporting off stops frames
    apb(1'b1, 12'h000, 32'h0);
    repeat (1000) @(posedge clk_sys);
    n = tx_cnt;
    repeat (300) @(posedge clk_sys);
    chk("off", 48'(tx_cnt - n), 48'h0);
    final_report();
  end
endmodule : crm_mapper_bench

`default_nettype wire
